// *** hdl/output_mapping_broker.sv ***
`timescale 1ns/1ps
`default_nettype none
module output_mapping_broker #(
	parameter int MS_CYCLES = output_mapping_pkg::MS_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic prod_valid,
	input wire output_mapping_pkg::prod_write_type prod,
	input wire logic cons_req,
	input wire output_mapping_pkg::cons_req_type cons,
	output logic cons_valid,
	output logic [15:0] cons_data,
	output logic cons_substituted,
	output logic irq
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	output_mapping_pkg::cfg_bank_type pending;
	output_mapping_pkg::cfg_bank_type active;
	logic [15:0] input_mem [0:output_mapping_pkg::INPUT_WORDS-1];
	logic [3:0] status;
	logic [3:0] mask;
	logic [3:0] next_status;
	logic restart_pulse;
	logic [2:0] expired;
	logic [2:0] expired_q;
	logic [2:0] fresh;
	logic aw_held;
	logic w_held;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic exec;
	logic [32:0] wr_old;
	logic [31:0] wr_val;
	logic wr_err;
	logic wr_bad;
	logic wr_cfg;
	logic wr_ctrl;
	logic [1:0] wr_cons;
	logic [5:0] wr_off;
	output_mapping_pkg::map_entry_type wr_entry;
	logic prod_ok;
	logic sel_ok;
	output_mapping_pkg::consumer_cfg_type cons_cfg;
	logic [6:0] res;
	logic [15:0] raw_word;
	logic exp_sel;
	logic [15:0] next_cons_data;
	logic [32:0] rd_word;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic src_ok(input logic [15:0] a);
		src_ok = (a >= output_mapping_pkg::INPUT_BASE) && (a <= output_mapping_pkg::INPUT_LAST);
	endfunction : src_ok

	function automatic logic area_ok(input logic [15:0] s, input logic [6:0] c);
		area_ok = (c == 7'h00) || ((s >= output_mapping_pkg::INPUT_BASE) &&
			(17'(s) + 17'(c) <= 17'(output_mapping_pkg::INPUT_LAST) + 17'h00001));
	endfunction : area_ok

	function automatic logic in_area(input output_mapping_pkg::consumer_cfg_type cf, input logic [15:0] a);
		in_area = 1'b0;
		for (int k = 0; k < output_mapping_pkg::NUM_ENTRIES; k++) begin
			if (cf.entry[k].cnt != 7'h00 && a >= cf.entry[k].src &&
				17'(a) < 17'(cf.entry[k].src) + 17'(cf.entry[k].cnt)) begin
				in_area = 1'b1;
			end
		end
	endfunction : in_area

	// output index -> {hit, memory word}; entries walked first to fourth
	function automatic logic [6:0] resolve(input output_mapping_pkg::consumer_cfg_type cf, input logic [8:0] idx);
		logic [8:0] rem;
		logic hit;
		logic [15:0] a;
		rem = idx;
		hit = 1'b0;
		a = output_mapping_pkg::INPUT_BASE;
		for (int k = 0; k < output_mapping_pkg::NUM_ENTRIES; k++) begin
			if (!hit) begin
				if (rem < {2'h0, cf.entry[k].cnt}) begin
					hit = 1'b1;
					a = 16'(cf.entry[k].src + 16'(rem));
				end else begin
					rem = 9'(rem - {2'h0, cf.entry[k].cnt});
				end
			end
		end
		resolve = {hit, 6'(a - output_mapping_pkg::INPUT_BASE)};
	endfunction : resolve

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
		end
	endfunction : merge

	// {error, data}; reads show the pending configuration
	function automatic logic [32:0] reg_read(input logic [7:0] a);
		output_mapping_pkg::consumer_cfg_type cf;
		output_mapping_pkg::map_entry_type en;
		logic [5:0] o;
		cf = pending[(a[7:6] == output_mapping_pkg::CTRL_BLOCK) ? 2'h0 : a[7:6]];
		en = cf.entry[a[output_mapping_pkg::ENTRY_LSB +: 2]];
		o = a[5:0];
		reg_read = {1'b1, 32'h00000000};
		if (a[7:6] == output_mapping_pkg::CTRL_BLOCK) begin
			case (o)
				output_mapping_pkg::STATUS_OFF: reg_read = {1'b0, 28'h0000000, status};
				output_mapping_pkg::MASK_OFF: reg_read = {1'b0, 28'h0000000, mask};
				output_mapping_pkg::RESTART_OFF: reg_read = {1'b0, 32'h00000000};
				output_mapping_pkg::STATE_OFF: reg_read = {1'b0, 28'h0000000, pending != active, expired};
				default: reg_read = {1'b1, 32'h00000000};
			endcase
		end else if (!o[output_mapping_pkg::CFG_AREA_BIT]) begin
			reg_read = o[output_mapping_pkg::ENTRY_CNT_BIT] ? {1'b0, 25'h0000000, en.cnt} : {1'b0, 16'h0000, en.src};
		end else if (o == output_mapping_pkg::DFLT_OFF) begin
			reg_read = {1'b0, 30'h00000000, cf.dflt};
		end else if (o == output_mapping_pkg::VTIME_OFF) begin
			reg_read = {1'b0, 24'h000000, cf.vtime};
		end
	endfunction : reg_read

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	assign exec = aw_held && w_held && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			awready <= 1'b1;
			wr_addr <= 8'h00;
		end else if (awvalid && awready) begin
			aw_held <= 1'b1;
			awready <= 1'b0;
			wr_addr <= awaddr;
		end else if (exec) begin
			aw_held <= 1'b0;
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			wready <= 1'b1;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
		end else if (wvalid && wready) begin
			w_held <= 1'b1;
			wready <= 1'b0;
			wr_data <= wdata;
			wr_strb <= wstrb;
		end else if (exec) begin
			w_held <= 1'b0;
			wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= output_mapping_pkg::RESP_OKAY;
		end else if (exec) begin
			bvalid <= 1'b1;
			bresp <= (wr_err || wr_bad) ? output_mapping_pkg::RESP_SLVERR : output_mapping_pkg::RESP_OKAY;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// write decode and validation
	// ----------------------------------------------------------------
	always_comb begin
		wr_old = reg_read(wr_addr);
		wr_val = merge(wr_old[31:0], wr_data, wr_strb);
		wr_err = wr_old[32];
		wr_cons = wr_addr[7:6];
		wr_off = wr_addr[5:0];
		wr_ctrl = !wr_err && (wr_cons == output_mapping_pkg::CTRL_BLOCK);
		wr_cfg = !wr_err && (wr_cons != output_mapping_pkg::CTRL_BLOCK);
		wr_entry = pending[wr_ctrl ? 2'h0 : wr_cons].entry[wr_addr[output_mapping_pkg::ENTRY_LSB +: 2]];
		wr_bad = 1'b0;
		if (wr_cfg) begin
			if (!wr_off[output_mapping_pkg::CFG_AREA_BIT]) begin
				if (wr_off[output_mapping_pkg::ENTRY_CNT_BIT]) begin
					wr_bad = (wr_val > 32'(output_mapping_pkg::INPUT_WORDS)) || !area_ok(wr_entry.src, 7'(wr_val));
				end else begin
					wr_bad = (wr_val[31:16] != 16'h0000) || !src_ok(wr_val[15:0]) || !area_ok(wr_val[15:0], wr_entry.cnt);
				end
			end else if (wr_off == output_mapping_pkg::DFLT_OFF) begin
				wr_bad = (wr_val < 32'h00000001) || (wr_val > 32'h00000003);
			end else begin
				wr_bad = (wr_val > 32'h000000FF);
			end
		end
	end

	// pending set, one independent bank per consumer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pending <= {output_mapping_pkg::NUM_CONS{output_mapping_pkg::CFG_RESET}};
		end else if (exec && wr_cfg && !wr_bad) begin
			if (!wr_off[output_mapping_pkg::CFG_AREA_BIT]) begin
				if (wr_off[output_mapping_pkg::ENTRY_CNT_BIT]) begin
					pending[wr_cons].entry[wr_addr[output_mapping_pkg::ENTRY_LSB +: 2]].cnt <= wr_val[6:0];
				end else begin
					pending[wr_cons].entry[wr_addr[output_mapping_pkg::ENTRY_LSB +: 2]].src <= wr_val[15:0];
				end
			end else if (wr_off == output_mapping_pkg::DFLT_OFF) begin
				pending[wr_cons].dflt <= wr_val[1:0];
			end else begin
				pending[wr_cons].vtime <= wr_val[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// restart and active mapping
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			restart_pulse <= 1'b0;
		end else begin
			restart_pulse <= exec && wr_ctrl && (wr_off == output_mapping_pkg::RESTART_OFF) &&
				wr_val[output_mapping_pkg::RESTART_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active <= {output_mapping_pkg::NUM_CONS{output_mapping_pkg::CFG_RESET}};
		end else if (restart_pulse) begin
			active <= pending;
		end
	end

	// ----------------------------------------------------------------
	// status, mask, interrupt
	// ----------------------------------------------------------------
	always_comb begin
		next_status = status;
		if (exec && wr_ctrl && wr_off == output_mapping_pkg::STATUS_OFF) begin
			next_status = status & ~wr_val[3:0];
		end
		// events set after the clear so a same-cycle event survives
		next_status[output_mapping_pkg::ST_MAP_ERR] = next_status[output_mapping_pkg::ST_MAP_ERR] | (exec && wr_bad);
		next_status[output_mapping_pkg::ST_TIMEOUT_LSB +: 3] = next_status[output_mapping_pkg::ST_TIMEOUT_LSB +: 3] |
			(expired & ~expired_q);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= 4'h0;
			mask <= 4'h0;
			expired_q <= 3'h0;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			expired_q <= expired;
			irq <= |(status & mask);
			if (exec && wr_ctrl && wr_off == output_mapping_pkg::MASK_OFF) begin
				mask <= wr_val[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	always_comb begin
		rd_word = reg_read(araddr);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= output_mapping_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_word[31:0];
			rresp <= rd_word[32] ? output_mapping_pkg::RESP_SLVERR : output_mapping_pkg::RESP_OKAY;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// producer side: input data area and freshness
	// ----------------------------------------------------------------
	assign prod_ok = prod_valid && src_ok(prod.addr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < output_mapping_pkg::INPUT_WORDS; i++) begin
				input_mem[i] <= 16'h0000;
			end
		end else if (prod_ok) begin
			input_mem[6'(prod.addr - output_mapping_pkg::INPUT_BASE)] <= prod.data;
		end
	end

	for (genvar c = 0; c < output_mapping_pkg::NUM_CONS; c++) begin : g_timer
		assign fresh[c] = prod_ok && in_area(active[c], prod.addr);
		validity_timer #(
			.MS_CYCLES(MS_CYCLES)
		) u_timer (
			.aclk(aclk),
			.aresetn(aresetn),
			.clear(fresh[c] || restart_pulse),
			.vtime(active[c].vtime),
			.expired(expired[c])
		);
	end

	// ----------------------------------------------------------------
	// consumer side
	// ----------------------------------------------------------------
	always_comb begin
		sel_ok = cons.sel < 2'(output_mapping_pkg::NUM_CONS);
		cons_cfg = active[sel_ok ? cons.sel : 2'h0];
		res = resolve(cons_cfg, cons.index);
		raw_word = res[6] ? input_mem[res[5:0]] : 16'h0000;
		exp_sel = sel_ok && expired[sel_ok ? cons.sel : 2'h0];
		next_cons_data = sel_ok ? raw_word : 16'h0000;
		if (exp_sel) begin
			case (cons_cfg.dflt)
				output_mapping_pkg::DFLT_ZERO: next_cons_data = 16'h0000;
				output_mapping_pkg::DFLT_ONES: next_cons_data = 16'hFFFF;
				default: next_cons_data = raw_word;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cons_valid <= 1'b0;
			cons_data <= 16'h0000;
			cons_substituted <= 1'b0;
		end else begin
			cons_valid <= cons_req;
			if (cons_req) begin
				cons_data <= next_cons_data;
				cons_substituted <= exp_sel;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_active_hold;
		@(posedge aclk) disable iff (!aresetn) !restart_pulse |=> $stable(active);
	endproperty
	a_active_hold: assert property (p_active_hold) else $error("active mapping changed without restart");

	property p_apply;
		@(posedge aclk) disable iff (!aresetn) exec && wr_ctrl && wr_off == output_mapping_pkg::RESTART_OFF && wr_val[0]
			|=> ##1 active == $past(pending, 2);
	endproperty
	a_apply: assert property (p_apply) else $error("restart did not apply pending mapping");

	property p_reject;
		@(posedge aclk) disable iff (!aresetn) exec && wr_bad
			|=> $stable(pending) && status[0] && bvalid && bresp == output_mapping_pkg::RESP_SLVERR;
	endproperty
	a_reject: assert property (p_reject) else $error("bad mapping accepted or not flagged");

	property p_reset_entry;
		@(posedge aclk) disable iff (!aresetn) $rose(aresetn) |-> active[2].entry[3].src == 16'h0001 &&
			active[0].entry[0].cnt == 7'h00 && pending[1].entry[2].src == 16'h0001;
	endproperty
	a_reset_entry: assert property (p_reset_entry) else $error("entry not at reset value");

	property p_zero_fill;
		@(posedge aclk) disable iff (!aresetn) cons_req && exp_sel && cons_cfg.dflt == 2'h1 |=> cons_data == 16'h0000;
	endproperty
	a_zero_fill: assert property (p_zero_fill) else $error("zero default not delivered");

	property p_ones_fill;
		@(posedge aclk) disable iff (!aresetn) cons_req && exp_sel && cons_cfg.dflt == 2'h2
			|=> cons_data == 16'hFFFF && cons_substituted;
	endproperty
	a_ones_fill: assert property (p_ones_fill) else $error("ones default not delivered");

	property p_fresh_pass;
		@(posedge aclk) disable iff (!aresetn) cons_req && sel_ok && !exp_sel |=> cons_data == $past(raw_word) && cons_valid;
	endproperty
	a_fresh_pass: assert property (p_fresh_pass) else $error("fresh data not passed through");

	property p_skip_empty;
		@(posedge aclk) disable iff (!aresetn) sel_ok && cons.index == 9'h000 && cons_cfg.entry[0].cnt == 7'h00 &&
			cons_cfg.entry[1].cnt != 7'h00 |-> res == {1'b1, 6'(cons_cfg.entry[1].src - 16'h1001)};
	endproperty
	a_skip_empty: assert property (p_skip_empty) else $error("empty entry not skipped");

	property p_independent;
		@(posedge aclk) disable iff (!aresetn) exec && wr_cons == 2'h0 |=> $stable(pending[1]) && $stable(pending[2]);
	endproperty
	a_independent: assert property (p_independent) else $error("consumer mappings not independent");
endmodule : output_mapping_broker
`default_nettype wire

// *** hdl/output_mapping_pkg.sv ***
package output_mapping_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_CONS = 3;
	localparam int NUM_ENTRIES = 4;
	localparam int INPUT_WORDS = 64;
	localparam logic [15:0] INPUT_BASE = 16'h1001;
	localparam logic [15:0] INPUT_LAST = 16'h1040;
	localparam logic [15:0] ENTRY_RESET_SRC = 16'h0001;
	// ----------------------------------------------------------------
	// default data selection
	// ----------------------------------------------------------------
	localparam logic [1:0] DFLT_ZERO = 2'h1;
	localparam logic [1:0] DFLT_ONES = 2'h2;
	localparam logic [1:0] DFLT_HOLD = 2'h3;
	localparam logic [7:0] VTIME_RESET = 8'h00;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int VALID_TICK_NS = 1000000;
	localparam int MS_CYCLES = VALID_TICK_NS / CLK_PERIOD_NS;
	// ----------------------------------------------------------------
	// register map: byte address = block * 0x40 + offset
	// ----------------------------------------------------------------
	localparam logic [1:0] CTRL_BLOCK = 2'h3;
	localparam int BLOCK_LSB = 6;
	localparam int ENTRY_LSB = 3;
	localparam int ENTRY_CNT_BIT = 2;
	localparam int CFG_AREA_BIT = 5;
	localparam logic [5:0] DFLT_OFF = 6'h20;
	localparam logic [5:0] VTIME_OFF = 6'h24;
	localparam logic [5:0] STATUS_OFF = 6'h00;
	localparam logic [5:0] MASK_OFF = 6'h04;
	localparam logic [5:0] RESTART_OFF = 6'h08;
	localparam logic [5:0] STATE_OFF = 6'h0C;
	localparam int ST_MAP_ERR = 0;
	localparam int ST_TIMEOUT_LSB = 1;
	localparam int RESTART_BIT = 0;
	localparam int STATE_PENDING_BIT = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] src;
		logic [6:0] cnt;
	} map_entry_type;
	typedef struct packed {
		map_entry_type [NUM_ENTRIES-1:0] entry;
		logic [1:0] dflt;
		logic [7:0] vtime;
	} consumer_cfg_type;
	typedef consumer_cfg_type [NUM_CONS-1:0] cfg_bank_type;
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
	} prod_write_type;
	typedef struct packed {
		logic [1:0] sel;
		logic [8:0] index;
	} cons_req_type;
	localparam consumer_cfg_type CFG_RESET = {{NUM_ENTRIES{ENTRY_RESET_SRC, 7'h00}}, DFLT_ZERO, VTIME_RESET};
endpackage : output_mapping_pkg

// *** hdl/validity_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module validity_timer #(
	parameter int MS_CYCLES = 50000
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clear,
	input wire logic [7:0] vtime,
	output logic expired
);
	logic [15:0] prescale;
	logic [7:0] elapsed;
	logic tick;

	assign tick = (prescale == 16'(MS_CYCLES - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn || clear || tick) begin
			prescale <= 16'h0000;
		end else begin
			prescale <= prescale + 16'h0001;
		end
	end

	// elapsed milliseconds since fresh data, saturating
	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			elapsed <= 8'h00;
		end else if (tick && elapsed != 8'hFF) begin
			elapsed <= elapsed + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			expired <= 1'b0;
		end else begin
			expired <= (vtime != 8'h00) && (elapsed >= vtime) && !clear;
		end
	end

	property p_zero_disables;
		@(posedge aclk) disable iff (!aresetn) vtime == 8'h00 |=> !expired;
	endproperty
	a_zero_disables: assert property (p_zero_disables) else $error("timer expired with check off");

	property p_fresh_clears;
		@(posedge aclk) disable iff (!aresetn) clear |=> !expired && elapsed == 8'h00;
	endproperty
	a_fresh_clears: assert property (p_fresh_clears) else $error("fresh data did not clear timeout");
endmodule : validity_timer
`default_nettype wire

// *** verif/cons_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cons_model (
	input wire logic aclk,
	input wire logic cons_valid,
	input wire logic [15:0] cons_data,
	input wire logic cons_substituted,
	output var logic cons_req,
	output var output_mapping_pkg::cons_req_type cons
);
	initial begin
		cons_req = 1'b0;
		cons = '0;
	end
	// one request; the answer is sampled one edge after it is taken
	task automatic fetch(input logic [1:0] s, input logic [8:0] i, output logic [17:0] r);
		@(posedge aclk);
		cons_req <= 1'b1;
		cons <= '{sel: s, index: i};
		@(posedge aclk);
		cons_req <= 1'b0;
		// released request lines carry garbage, not the last request
		cons <= {~s, ~i};
		@(posedge aclk);
		r = {cons_valid, cons_substituted, cons_data};
	endtask : fetch
endmodule : cons_model
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic aclk, aresetn;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic prod_valid, cons_req, cons_valid, cons_substituted, irq;
	output_mapping_pkg::prod_write_type prod;
	output_mapping_pkg::cons_req_type cons;
	logic [15:0] cons_data, ex;
	logic [17:0] cr;
	logic [26:0] rows [8];
	int bad_count, n_compared, cycles;
	output_mapping_broker #(.MS_CYCLES(10)) i_output_mapping_broker (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .prod_valid, .prod, .cons_req, .cons, .cons_valid, .cons_data,
		.cons_substituted, .irq);
	cons_model i_cons_model (.aclk, .cons_valid, .cons_data, .cons_substituted, .cons_req, .cons);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic stop_test;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wc
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rv = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic put(input logic [15:0] a, input logic [15:0] d);
		@(posedge aclk);
		prod_valid <= 1'b1;
		prod <= '{addr: a, data: d};
		@(posedge aclk);
		prod_valid <= 1'b0;
	endtask : put
	task automatic fc(input logic [1:0] s, input logic [8:0] i, input logic [17:0] e);
		i_cons_model.fetch(s, i, cr);
		chk({14'h0, cr}, {14'h0, e});
	endtask : fc
	task automatic restart;
		wc(8'hC8, 32'h1, output_mapping_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
	endtask : restart
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 6000) begin
			bad_count++;
			stop_test;
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata, prod_valid, prod} = '0;
		wstrb = 4'hF;
		aresetn = 1'b0;
		rows = '{{2'h0, 9'h000, 16'hA001}, {2'h0, 9'h001, 16'hA002}, {2'h0, 9'h002, 16'hA010},
			{2'h0, 9'h003, 16'h0000}, {2'h1, 9'h000, 16'hA010}, {2'h2, 9'h000, 16'hA020},
			{2'h2, 9'h001, 16'h0000}, {2'h3, 9'h000, 16'h0000}};
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h00);
		chk(rv, 32'h1);
		rd(8'h1C);
		chk(rv, 32'h0);
		rd(8'hA0);
		chk(rv, 32'h1);
		rd(8'h64);
		chk(rv, 32'h0);
		rd(8'hF0);
		chk({30'h0, rs}, {30'h0, output_mapping_pkg::RESP_SLVERR});
		$display("test reset done");
		wc(8'h00, 32'h1001, output_mapping_pkg::RESP_OKAY);
		wc(8'h04, 32'h2, output_mapping_pkg::RESP_OKAY);
		wc(8'h10, 32'h1010, output_mapping_pkg::RESP_OKAY);
		wc(8'h14, 32'h1, output_mapping_pkg::RESP_OKAY);
		wc(8'h80, 32'h1020, output_mapping_pkg::RESP_OKAY);
		wc(8'h84, 32'h1, output_mapping_pkg::RESP_OKAY);
		wc(8'h48, 32'h1010, output_mapping_pkg::RESP_OKAY);
		wc(8'h4C, 32'h1, output_mapping_pkg::RESP_OKAY);
		put(16'h1001, 16'hA001);
		put(16'h1002, 16'hA002);
		put(16'h1010, 16'hA010);
		put(16'h1020, 16'hA020);
		fc(2'h0, 9'h000, 18'h20000);
		restart;
		for (int k = 0; k < 8; k++) begin
			fc(rows[k][26:25], rows[k][24:16], {2'h2, rows[k][15:0]});
		end
		$display("test mapping done");
		wc(8'h40, 32'h1040, output_mapping_pkg::RESP_OKAY);
		wc(8'h44, 32'h2, output_mapping_pkg::RESP_SLVERR);
		wc(8'h40, 32'h0FFF, output_mapping_pkg::RESP_SLVERR);
		rd(8'h40);
		chk(rv, 32'h1040);
		wc(8'hC4, 32'h1, output_mapping_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		wc(8'hC0, 32'hF, output_mapping_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		$display("test error done");
		wc(8'h24, 32'h2, output_mapping_pkg::RESP_OKAY);
		for (int d = 1; d <= 3; d++) begin
			wc(8'h20, 32'(d), output_mapping_pkg::RESP_OKAY);
			restart;
			repeat (60) @(posedge aclk);
			ex = (d == 1) ? 16'h0000 : (d == 2) ? 16'hFFFF : 16'hA001;
			fc(2'h0, 9'h000, {2'h3, ex});
		end
		rd(8'hCC);
		chk(rv, 32'h1);
		rd(8'hC0);
		chk(rv, 32'h2);
		fc(2'h2, 9'h000, {2'h2, 16'hA020});
		put(16'h1001, 16'hB001);
		repeat (2) @(posedge aclk);
		fc(2'h0, 9'h000, {2'h2, 16'hB001});
		$display("test timeout done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h00);
		chk(rv, 32'h1);
		fc(2'h0, 9'h000, 18'h20000);
		$display("test mid-run reset done");
		stop_test;
	end
endmodule : tb_top
`default_nettype wire
